/* File: logic/status_bank_defs.vh */
// status and telemetry bank constants: command codes, bit positions,
// fixed patterns and field widths.
// assumes inclusion by bare name from the bank's single design file.
`ifndef STATUS_BANK_DEFS_VH
`define STATUS_BANK_DEFS_VH

// ****************************************************************
// command codes
// ****************************************************************
`define CMD_TEMP_STATUS   8'h7d
`define CMD_COMM_STATUS   8'h7e
`define CMD_VIN_READ      8'h88
`define CMD_VOUT_READ     8'h8b
`define CMD_IOUT_READ     8'h8c
`define CMD_TEMP_READ     8'h8d
`define CMD_EFF_READ      8'h95
`define CMD_POUT_READ     8'h96
`define CMD_PIN_READ      8'h97

// ****************************************************************
// temperature status bit positions
// ****************************************************************
`define TS_EXT_FAULT      7
`define TS_EXT_WARN       6
`define TS_STG_FAULT      3
`define TS_STG_WARN       2

// ****************************************************************
// communication status bit positions
// ****************************************************************
`define CS_INVALID_CMD    7
`define CS_INVALID_DATA   6
`define CS_PEC            5
`define CS_CRC            4
`define CS_PWD_MATCH      3
`define CS_FAULT_STORE    2
`define CS_FRAMING        1
`define CS_SIGNATURE      0

// ****************************************************************
// telemetry fixed patterns and widths
// ****************************************************************
`define VIN_PATTERN       6'h3b
`define IOUT_PATTERN      4'he
`define VIN_W             10
`define VOUT_W            12
`define IOUT_W            12
`define TEMP_W            11
`define EFF_W             9
`define PWR_W             11
`define STATUS_RST        8'h00
`define WORD_ZERO         16'h0000

`endif

/* File: logic/status_telemetry_bank.v */
// status and telemetry bank: latched fault flags and read-only telemetry
// words, read by command code from the bus front end.
// compares temperatures itself; assumes the bus and memory engines are outside and
// present one-cycle event pulses synchronous to mclk_i.
`include "status_bank_defs.vh"

// Functional notes
// - external sense over fault limit sets temperature bit 7 until clear.
// - external sense over warn limit sets temperature bit 6 until clear.
// - stage sense over fault limit sets temperature bit 3 until clear.
// - stage sense over warn limit sets temperature bit 2 until clear.
// - reserved bits ignore writes and always read zero.
// - unsupported command code sets communication bit 7, latched.
// - invalid data or excess written bytes set communication bit 6.
// - wrong check byte on write blocks execution, sets bit 5.
// - restore check mismatch blocks start-up and sets bit 4.
// - write protect makes registers read-only unless the key matches; bit 3 follows key match live.
// - protective shutdown triggers fault record and sets bit 2.
// - too few bits or bytes, or too many read, set bit 1.
// - signature mismatch aborts restore at once and sets bit 0.
// - input voltage word has 111011 above ten data bits.
// - output voltage in bits 11:0, upper four bits zero.
// - current word has 1110 above twelve bits, scale by option.
// - temperature in bits 10:0, upper five bits zero.
// - efficiency in bits 8:0, upper seven bits zero.
// - output power eleven bits, scale doubles with option.
// - input power bits 10:0, same scale option.
// - summary temperature bit sets on any temperature fault or warning.
module status_telemetry_bank #(
    parameter TEMP_W = `TEMP_W
) (
    input  wire              mclk_i,
    input  wire              reset_n_i,
    // temperature comparison inputs
    input  wire [TEMP_W-1:0] external_temp_sense_i,
    input  wire [TEMP_W-1:0] stage_temp_sense_i,
    input  wire [TEMP_W-1:0] external_temp_fault_limit_i,
    input  wire [TEMP_W-1:0] external_temp_warn_limit_i,
    input  wire [TEMP_W-1:0] stage_temp_fault_limit_i,
    input  wire [TEMP_W-1:0] stage_temp_warn_limit_i,
    // bus engine events
    input  wire              clear_faults_i,
    input  wire              invalid_cmd_i,
    input  wire              invalid_data_i,
    input  wire              framing_fault_i,
    input  wire              write_done_i,
    input  wire              write_pec_present_i,
    input  wire              write_pec_ok_i,
    // memory engine events
    input  wire              restore_start_i,
    input  wire              signature_ok_i,
    input  wire              restore_done_i,
    input  wire              crc_ok_i,
    input  wire              protect_shutdown_i,
    // password, protection and scale option
    input  wire [15:0]       supplied_key_i,
    input  wire [15:0]       user_password_word_i,
    input  wire              write_protect_en_i,
    input  wire              total_current_scale_select_i,
    // telemetry samples
    input  wire [`VIN_W-1:0] vin_sample_i,
    input  wire [`VOUT_W-1:0] vout_sample_i,
    input  wire [`IOUT_W-1:0] iout_fine_i,
    input  wire [TEMP_W-1:0] temp_sample_i,
    input  wire [`EFF_W-1:0] eff_sample_i,
    input  wire [`PWR_W+1:0] pout_fine_i,
    input  wire [`PWR_W+1:0] pin_fine_i,
    // read port
    input  wire              rd_en_i,
    input  wire [7:0]        rd_cmd_i,
    output reg  [15:0]       rd_data_o,
    output reg               rd_valid_o,
    output reg               rd_unmapped_o,
    // control outputs
    output wire              write_exec_o,
    output wire              write_allowed_o,
    output reg               fault_record_o,
    output reg               restore_abort_o,
    output wire              startup_block_o,
    output wire [7:0]        temp_status_o,
    output wire [7:0]        comm_status_o,
    output wire              summary_temp_o
);

    // ****************************************************************
    // latched flags
    // ****************************************************************
    wire [3:0]  temp_flags_r;   // {ext fault, ext warn, stg fault, stg warn}
    wire [6:0]  comm_flags_r;   // all comm flags except live key match
    wire        summary_temp_r;
    reg         startup_block_r;
    reg         restore_act_r;
    wire        pec_bad;
    wire        pwd_match;
    wire [3:0]  temp_set;
    wire [6:0]  comm_set;

    assign temp_set[3] = external_temp_sense_i > external_temp_fault_limit_i;
    assign temp_set[2] = external_temp_sense_i > external_temp_warn_limit_i;
    assign temp_set[1] = stage_temp_sense_i > stage_temp_fault_limit_i;
    assign temp_set[0] = stage_temp_sense_i > stage_temp_warn_limit_i;

    assign pec_bad = write_done_i & write_pec_present_i & ~write_pec_ok_i;
    assign write_exec_o = write_done_i & ~pec_bad & write_allowed_o;
    assign pwd_match = (supplied_key_i == user_password_word_i);
    assign write_allowed_o = ~write_protect_en_i | pwd_match;

    // comm set terms, index 6..0 = bits 7,6,5,4,2,1,0
    // unsupported command
    assign comm_set[6] = invalid_cmd_i;
    assign comm_set[5] = invalid_data_i;
    assign comm_set[4] = pec_bad;
    assign comm_set[3] = restore_done_i & restore_act_r & ~crc_ok_i;
    assign comm_set[2] = protect_shutdown_i;
    assign comm_set[1] = framing_fault_i;
    assign comm_set[0] = restore_start_i & ~signature_ok_i;

    // ****************************************************************
    // latched flag cells, one per status bit except the live key match, plus the summary
    // ****************************************************************
    // external fault latch
    sticky_flag ext_fault_flag (
        .mclk_i    (mclk_i),
        .reset_n_i (reset_n_i),
        .set_i     (temp_set[3]),
        .clear_i   (clear_faults_i),
        .flag_o    (temp_flags_r[3])
    );

    sticky_flag ext_warn_flag (
        .mclk_i    (mclk_i),
        .reset_n_i (reset_n_i),
        .set_i     (temp_set[2]),
        .clear_i   (clear_faults_i),
        .flag_o    (temp_flags_r[2])
    );

    sticky_flag stg_fault_flag (
        .mclk_i    (mclk_i),
        .reset_n_i (reset_n_i),
        .set_i     (temp_set[1]),
        .clear_i   (clear_faults_i),
        .flag_o    (temp_flags_r[1])
    );

    sticky_flag stg_warn_flag (
        .mclk_i    (mclk_i),
        .reset_n_i (reset_n_i),
        .set_i     (temp_set[0]),
        .clear_i   (clear_faults_i),
        .flag_o    (temp_flags_r[0])
    );

    sticky_flag summary_flag (
        .mclk_i    (mclk_i),
        .reset_n_i (reset_n_i),
        .set_i     (|temp_set),
        .clear_i   (clear_faults_i),
        .flag_o    (summary_temp_r)
    );

    sticky_flag cmd_flag (
        .mclk_i    (mclk_i),
        .reset_n_i (reset_n_i),
        .set_i     (comm_set[6]),
        .clear_i   (clear_faults_i),
        .flag_o    (comm_flags_r[6])
    );

    sticky_flag data_flag (
        .mclk_i    (mclk_i),
        .reset_n_i (reset_n_i),
        .set_i     (comm_set[5]),
        .clear_i   (clear_faults_i),
        .flag_o    (comm_flags_r[5])
    );

    sticky_flag pec_flag (
        .mclk_i    (mclk_i),
        .reset_n_i (reset_n_i),
        .set_i     (comm_set[4]),
        .clear_i   (clear_faults_i),
        .flag_o    (comm_flags_r[4])
    );

    sticky_flag crc_flag (
        .mclk_i    (mclk_i),
        .reset_n_i (reset_n_i),
        .set_i     (comm_set[3]),
        .clear_i   (clear_faults_i),
        .flag_o    (comm_flags_r[3])
    );

    sticky_flag record_flag (
        .mclk_i    (mclk_i),
        .reset_n_i (reset_n_i),
        .set_i     (comm_set[2]),
        .clear_i   (clear_faults_i),
        .flag_o    (comm_flags_r[2])
    );

    sticky_flag framing_flag (
        .mclk_i    (mclk_i),
        .reset_n_i (reset_n_i),
        .set_i     (comm_set[1]),
        .clear_i   (clear_faults_i),
        .flag_o    (comm_flags_r[1])
    );

    sticky_flag signature_flag (
        .mclk_i    (mclk_i),
        .reset_n_i (reset_n_i),
        .set_i     (comm_set[0]),
        .clear_i   (clear_faults_i),
        .flag_o    (comm_flags_r[0])
    );

    // ****************************************************************
    // restore sequencing and fault record strobe
    // ****************************************************************
    // restore tracking, start-up block, abort and record pulses
    always @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            restore_act_r   <= 1'b0;
            startup_block_r <= 1'b0;
            restore_abort_o <= 1'b0;
            fault_record_o  <= 1'b0;
        end else begin
            restore_abort_o <= restore_start_i & ~signature_ok_i;
            fault_record_o  <= protect_shutdown_i;
            if (restore_start_i) begin
                restore_act_r   <= signature_ok_i;
                startup_block_r <= ~signature_ok_i;
            end else if (restore_done_i && restore_act_r) begin
                restore_act_r   <= 1'b0;
                startup_block_r <= ~crc_ok_i;
            end
        end
    end
    assign startup_block_o = startup_block_r;

    // ****************************************************************
    // status byte assembly
    // ****************************************************************
    // reserved bits zero
    assign temp_status_o = {temp_flags_r[3], temp_flags_r[2], 2'b00,
                            temp_flags_r[1], temp_flags_r[0], 2'b00};
    assign comm_status_o = {comm_flags_r[6:3], pwd_match,
                            comm_flags_r[2:0]};
    assign summary_temp_o = summary_temp_r;

    // ****************************************************************
    // telemetry scaling and read mux
    // ****************************************************************
    wire [`IOUT_W-1:0] iout_scaled;
    wire [`PWR_W-1:0]  pout_scaled;
    wire [`PWR_W-1:0]  pin_scaled;
    reg  [15:0]        rd_word;
    reg                rd_hit;

    assign iout_scaled = total_current_scale_select_i ?
                         {1'b0, iout_fine_i[`IOUT_W-1:1]} : iout_fine_i;
    assign pout_scaled = total_current_scale_select_i ?
                         pout_fine_i[`PWR_W+1:2] : pout_fine_i[`PWR_W:1];
    assign pin_scaled  = total_current_scale_select_i ?
                         pin_fine_i[`PWR_W+1:2] : pin_fine_i[`PWR_W:1];

    // read decode
    always @* begin
        rd_word = `WORD_ZERO;
        rd_hit  = 1'b1;
        case (rd_cmd_i)
            `CMD_TEMP_STATUS: rd_word = {8'h00, temp_status_o};
            `CMD_COMM_STATUS: rd_word = {8'h00, comm_status_o};
            `CMD_VIN_READ:  rd_word = {`VIN_PATTERN, vin_sample_i};
            `CMD_VOUT_READ: rd_word = {4'h0, vout_sample_i};
            `CMD_IOUT_READ: rd_word = {`IOUT_PATTERN, iout_scaled};
            `CMD_TEMP_READ: rd_word = {5'h00, temp_sample_i};
            `CMD_EFF_READ:  rd_word = {7'h00, eff_sample_i};
            `CMD_POUT_READ: rd_word = {5'h00, pout_scaled};
            `CMD_PIN_READ:  rd_word = {5'h00, pin_scaled};
            default:        rd_hit  = 1'b0;
        endcase
    end

    // registered read answer
    always @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rd_data_o     <= `WORD_ZERO;
            rd_valid_o    <= 1'b0;
            rd_unmapped_o <= 1'b0;
        end else begin
            rd_valid_o    <= rd_en_i & rd_hit;
            rd_unmapped_o <= rd_en_i & ~rd_hit;
            if (rd_en_i) begin
                rd_data_o <= rd_hit ? rd_word : `WORD_ZERO;
            end
        end
    end

endmodule // status_telemetry_bank

// ****************************************************************
// sticky fault flag cell
// ****************************************************************
// one latched status bit: an event sets it, clear-faults drops it,
// and an event in the clearing cycle keeps it set so nothing is lost
module sticky_flag (
    input  wire mclk_i,
    input  wire reset_n_i,
    input  wire set_i,
    input  wire clear_i,
    output reg  flag_o
);

    reg         flag_nxt;

    always @* begin
        flag_nxt = flag_o;
        if (clear_i) begin
            flag_nxt = 1'b0;
        end
        if (set_i) begin
            flag_nxt = 1'b1;
        end
    end

    // flag register
    always @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            flag_o <= 1'b0;
        end else begin
            flag_o <= flag_nxt;
        end
    end

endmodule // sticky_flag

/* File: verif/pmbus_host_model.sv */
// host model: sends queued read command codes, one per cycle
// assumes the bench fills cmd_q; changes land on the falling edge
module pmbus_host_model (
    input  wire logic  mclk_i,
    output logic       rd_en_o,
    output logic [7:0] rd_cmd_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] cmd_q[$];
    // idle code is inverted each cycle so a stale code never looks held
    always @(negedge mclk_i) begin
        rd_en_o <= cmd_q.size() != 0;
        rd_cmd_o <= cmd_q.size() != 0 ? cmd_q.pop_front() : ~rd_cmd_o;
    end
    initial {rd_en_o, rd_cmd_o} = 9'h000;
endmodule // pmbus_host_model

/* File: verif/status_bank_sva.sv */
// checker for the status bank: flag latching, refusal, control pulses
// assumes it is bound into status_telemetry_bank with its one clock
module status_bank_sva #(
    parameter TEMP_W = 11
) (
    input wire              mclk_i,
    input wire              reset_n_i,
    input wire [TEMP_W-1:0] external_temp_sense_i,
    input wire [TEMP_W-1:0] external_temp_fault_limit_i,
    input wire              invalid_cmd_i,
    input wire              write_done_i,
    input wire              write_pec_present_i,
    input wire              write_pec_ok_i,
    input wire              restore_start_i,
    input wire              signature_ok_i,
    input wire              protect_shutdown_i,
    input wire [15:0]       supplied_key_i,
    input wire [15:0]       user_password_word_i,
    input wire              write_exec_o,
    input wire              fault_record_o,
    input wire              restore_abort_o,
    input wire [7:0]        temp_status_o,
    input wire [7:0]        comm_status_o,
    input wire              summary_temp_o
);
    // one clock domain, quiet while reset is low
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!reset_n_i);
    property p_ext;
        external_temp_sense_i > external_temp_fault_limit_i
            |=> temp_status_o[7];
    endproperty
    a_ext: assert property (p_ext) else $error("fault bit missed");
    property p_rsv; (temp_status_o & 8'h33) == 8'h00; endproperty
    a_rsv: assert property (p_rsv) else $error("spare bit set");
    property p_cmd; invalid_cmd_i |=> comm_status_o[7]; endproperty
    a_cmd: assert property (p_cmd) else $error("cmd bit missed");
    property p_pec;
        write_done_i && write_pec_present_i && !write_pec_ok_i
            |-> !write_exec_o ##1 comm_status_o[5];
    endproperty
    a_pec: assert property (p_pec) else $error("bad check ran");
    property p_pwd;
        comm_status_o[3] == (supplied_key_i == user_password_word_i);
    endproperty
    a_pwd: assert property (p_pwd) else $error("key flag wrong");
    property p_rec; protect_shutdown_i |=> fault_record_o && comm_status_o[2];
    endproperty
    a_rec: assert property (p_rec) else $error("record missed");
    property p_abt;
        restore_start_i && !signature_ok_i
            |=> restore_abort_o && comm_status_o[0];
    endproperty
    a_abt: assert property (p_abt) else $error("abort missed");
    property p_sum; temp_status_o != 8'h00 |-> summary_temp_o; endproperty
    a_sum: assert property (p_sum) else $error("summary low");
endmodule // status_bank_sva
bind status_telemetry_bank status_bank_sva #(.TEMP_W(TEMP_W)) sva_i (.*);

/* File: verif/tb_pmbus_status_telemetry_bank.sv */
// bench for the status bank: event table, write checks, host reads
// assumes default field widths, one 200 MHz clock, async low reset
module tb_pmbus_status_telemetry_bank;
    timeunit 1ns;
    timeprecision 1ps;
    logic        mclk_i = 1'b0, reset_n_i = 1'b0, write_done_i = 1'b0;
    logic        write_pec_present_i = 1'b0, write_pec_ok_i = 1'b0;
    logic        restore_start_i = 1'b0, signature_ok_i = 1'b0;
    logic        restore_done_i = 1'b0, crc_ok_i = 1'b0;
    logic        write_protect_en_i = 1'b0, total_current_scale_select_i;
    logic [10:0] external_temp_sense_i = 11'h0, stage_temp_sense_i = 11'h0;
    logic [10:0] external_temp_fault_limit_i = 11'h200, temp_sample_i;
    logic [10:0] stage_temp_fault_limit_i = 11'h200;
    logic [10:0] external_temp_warn_limit_i = 11'h100;
    logic [10:0] stage_temp_warn_limit_i = 11'h100;
    logic [15:0] supplied_key_i = 16'h0, user_password_word_i = 16'h5a3c;
    logic [9:0]  vin_sample_i;
    logic [11:0] vout_sample_i, iout_fine_i;
    logic [8:0]  eff_sample_i;
    logic [12:0] pout_fine_i, pin_fine_i;
    logic [7:0]  ev = 8'h00, rd_cmd_i, temp_status_o, comm_status_o;
    logic        rd_en_i, rd_valid_o, rd_unmapped_o, write_exec_o;
    logic        write_allowed_o, fault_record_o, restore_abort_o;
    logic        startup_block_o, summary_temp_o;
    logic [15:0] rd_data_o;
    logic [16:0] exp_q[$];
    int          err_total = 0, total_checks = 0, cyc = 0;
    // ext sense, stage sense, event pulses, expected temp and comm bytes
    logic [45:0] tab [11] = '{
        {11'h200, 11'h0, 8'h00, 8'h40, 8'h00},
        {11'h201, 11'h0, 8'h00, 8'hc0, 8'h00},
        {11'h0, 11'h200, 8'h00, 8'hc4, 8'h00},
        {11'h0, 11'h201, 8'h00, 8'hcc, 8'h00},
        {11'h0, 11'h0, 8'h01, 8'h00, 8'h00},
        {11'h0, 11'h0, 8'h80, 8'h00, 8'h80},
        {11'h0, 11'h0, 8'h40, 8'h00, 8'hc0},
        {11'h0, 11'h0, 8'h04, 8'h00, 8'hc4},
        {11'h0, 11'h0, 8'h02, 8'h00, 8'hc6},
        {11'h0, 11'h0, 8'h81, 8'h00, 8'h80},
        {11'h0, 11'h0, 8'h01, 8'h00, 8'h00}};
    // ****************************************************************
    // design, host model and clock
    // ****************************************************************
    status_telemetry_bank uut (.invalid_cmd_i(ev[7]), .invalid_data_i(ev[6]),
        .protect_shutdown_i(ev[2]), .framing_fault_i(ev[1]),
        .clear_faults_i(ev[0]), .*);
    pmbus_host_model host (.mclk_i(mclk_i), .rd_en_o(rd_en_i),
        .rd_cmd_o(rd_cmd_i));
    always #2.5 mclk_i = ~mclk_i;
    task automatic chk(input logic [16:0] a, input logic [16:0] e);
        total_checks++;
        if (a !== e) begin
            err_total++;
            $display("Error at %0t: got %h expected %h", $time, a, e);
        end
    endtask
    task automatic rd(input logic [7:0] c, input logic [16:0] e);
        exp_q.push_back(e);
        host.cmd_q.push_back(c);
    endtask
    task automatic drain();
        for (int i = 0; i < 20 && exp_q.size() != 0; i++) @(negedge mclk_i);
        chk(17'(exp_q.size()), 17'h0);
    endtask
    task automatic summarize();
        $display("checks %0d errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // match answers to the oldest note; cut a hang short
    always @(posedge mclk_i) begin
        #1;
        if (rd_valid_o === 1'b1 || rd_unmapped_o === 1'b1)
            chk({rd_unmapped_o, rd_data_o},
                exp_q.size() != 0 ? exp_q.pop_front() : 17'h1ffff);
        cyc++;
        if (cyc == 2000) begin
            err_total++;
            summarize();
        end
    end
    initial begin
        void'($urandom(85));
        {total_current_scale_select_i, vin_sample_i, vout_sample_i} = 23'h0;
        {iout_fine_i, temp_sample_i, eff_sample_i, pout_fine_i} = 45'h0;
        pin_fine_i = 13'h0;
        repeat (5) @(negedge mclk_i);
        reset_n_i = 1'b1;
        for (int s = 0; s < 2; s++) begin
            total_current_scale_select_i = s[0];
            {vin_sample_i, vout_sample_i} = 22'($urandom);
            {iout_fine_i, temp_sample_i, eff_sample_i} = $urandom;
            pout_fine_i = 13'($urandom % 4096);
            pin_fine_i = 13'($urandom % 4096);
            @(negedge mclk_i);
            rd(8'h88, {7'h3b, vin_sample_i}); // vin word
            rd(8'h8b, {5'h00, vout_sample_i}); // vout word
            rd(8'h8c, {5'h0e, iout_fine_i >> s}); // current word
            rd(8'h8d, {6'h00, temp_sample_i}); // temp word
            rd(8'h95, {8'h00, eff_sample_i}); // efficiency
            rd(8'h96, {6'h00, 11'(pout_fine_i >> (s + 1))}); // out power
            rd(8'h97, {6'h00, 11'(pin_fine_i >> (s + 1))}); // in power
            rd(8'h7f, 17'h10000); // unmapped code refused
            drain();
        end
        foreach (tab[i]) begin
            {external_temp_sense_i, stage_temp_sense_i, ev} = tab[i][45:16];
            @(negedge mclk_i);
            ev = 8'h00;
            @(negedge mclk_i);
            chk({summary_temp_o, temp_status_o, comm_status_o},
                {tab[i][15:8] != 8'h00, tab[i][15:0]}); // flags
        end
        {write_done_i, write_pec_present_i} = 2'h3;
        #0.5;
        chk({16'h0, write_exec_o}, 17'h0); // bad
        @(negedge mclk_i);
        write_pec_ok_i = 1'b1;
        #0.5;
        chk({16'h0, write_exec_o}, 17'h1); // good
        write_protect_en_i = 1'b1;
        #0.5;
        chk({15'h0, write_allowed_o, write_exec_o}, 17'h0); // locked
        supplied_key_i = user_password_word_i;
        #0.5;
        chk({15'h0, write_allowed_o, comm_status_o[3]}, 17'h3); // key
        @(negedge mclk_i);
        {write_done_i, supplied_key_i} = 17'h0;
        restore_start_i = 1'b1;
        @(negedge mclk_i);
        {restore_start_i, signature_ok_i} = 2'h1;
        chk({16'h0, startup_block_o}, 17'h1); // bad signature
        @(negedge mclk_i);
        restore_start_i = 1'b1;
        @(negedge mclk_i);
        {restore_start_i, restore_done_i} = 2'h1;
        @(negedge mclk_i);
        restore_done_i = 1'b0;
        chk({16'h0, startup_block_o}, 17'h1); // bad crc
        rd(8'h7e, 17'h00031); // comm byte
        rd(8'h7d, 17'h00000); // temp byte
        drain();
        summarize();
    end
endmodule // tb_pmbus_status_telemetry_bank
